/* hdl/rx_ctrl_pkg.sv */
// Purpose: shared constants and types of the receiver control core
// Assumes: i_clk is the crystal oscillator clock
// Notes:   register offsets are byte addresses on a 32-bit APB
package rx_ctrl_pkg;
  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int DIV_MODE_LO   = 10;
  localparam int DIV_MODE_HI   = 14;
  localparam int EXT_PER0      = 8;
  localparam int EXT_PER1      = 4;
  localparam int EXT_PER2      = 2;
  localparam int EXT_PER3      = 1;
  // start-up length in half base ticks: 896.5, 512.5, 512.5, 320.5 ticks
  localparam int STARTUP_HALF0 = 1793;
  localparam int STARTUP_HALF1 = 1025;
  localparam int STARTUP_HALF2 = 1025;
  localparam int STARTUP_HALF3 = 641;
  localparam int GAP_EXT       = 10;

  // ***************************************************************
  // registers
  // ***************************************************************
  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_STATUS    = 12'h004;
  localparam logic [31:0] CTRL_RST       = 32'h00000000;
  localparam int          CTRL_BAND3_BIT = 0;
  localparam int          STAT_STATE_LSB = 0;
  localparam int          STAT_BAND_LSB  = 4;
  localparam int          STAT_DATA_BIT  = 8;

  typedef enum logic [1:0] {ST_SLEEP, ST_STARTUP, ST_WAIT_FALL, ST_RECEIVE} rx_state_t;
endpackage

/* hdl/rx_tick_gen.sv */
// Purpose: base, half and extended tick pulses from the oscillator clock
// Assumes: mode and band inputs synchronous to i_clk
// Notes:   pulses are one clock wide while i_ce stays high; i_ce low holds them
`timescale 1ns/100ps
module rx_tick_gen (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_ce,
  input  wire logic       i_mode,
  input  wire logic [1:0] i_rate_band,
  output logic            o_base_tick,
  output logic            o_half_tick,
  output logic            o_ext_tick
);
  import rx_ctrl_pkg::*;

  logic [3:0] div_cnt_reg;
  logic [2:0] ext_cnt_reg;
  logic       base_tick_reg;
  logic       half_tick_reg;
  logic       ext_tick_reg;

  wire  [3:0] div_w    = i_mode ? 4'(DIV_MODE_HI) : 4'(DIV_MODE_LO);
  wire        div_end  = (div_cnt_reg >= div_w - 4'h1);
  wire        div_mid  = (div_cnt_reg == (div_w >> 1) - 4'h1);
  wire  [2:0] ext_per  = (i_rate_band == 2'h0) ? 3'(EXT_PER0 - 1) :
                         (i_rate_band == 2'h1) ? 3'(EXT_PER1 - 1) :
                         (i_rate_band == 2'h2) ? 3'(EXT_PER2 - 1) : 3'(EXT_PER3 - 1);
  wire        ext_end  = (ext_cnt_reg >= ext_per);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      div_cnt_reg   <= 4'h0;
      ext_cnt_reg   <= 3'h0;
      base_tick_reg <= 1'b0;
      half_tick_reg <= 1'b0;
      ext_tick_reg  <= 1'b0;
    end else if (i_ce) begin
      div_cnt_reg   <= div_end ? 4'h0 : div_cnt_reg + 4'h1; // [R1]
      base_tick_reg <= div_end;
      half_tick_reg <= div_end | div_mid;
      ext_tick_reg  <= div_end & ext_end; // [R2]
      if (div_end) begin
        ext_cnt_reg <= ext_end ? 3'h0 : ext_cnt_reg + 3'h1;
      end
    end
  end

  assign o_base_tick = base_tick_reg;
  assign o_half_tick = half_tick_reg;
  assign o_ext_tick  = ext_tick_reg;

  // ***************************************************************
  // checks
  // ***************************************************************
  a_ext_on_base: assert property (@(posedge i_clk) disable iff (i_reset) // [R2]
    ext_tick_reg |-> base_tick_reg) else $error("extended tick without base tick");
  a_base_spacing: assert property (@(posedge i_clk) disable iff (i_reset) // [R1]
    (base_tick_reg && i_ce && !i_mode) ##1 (i_ce && !i_mode) [*8] |-> !base_tick_reg)
    else $error("base tick period too short");
endmodule

/* hdl/rx_ctrl_core.sv */
// Purpose: sleep/start-up/receive sequencing and data re-timing of the receiver
// Assumes: all pin inputs synchronous to i_clk; APB slave for control and status
// Notes:   i_ce low freezes everything including the bus slave
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/100ps
// Summary of operation
// [R1] base tick is oscillator clock divided by 10, or 14 with mode high
// [R2] extended tick is 8, 4, 2 or 1 base ticks for bands 0 to 3
// [R3] enable low keeps the receiver asleep
// [R4] asleep: processing disabled, data output held low, input ignored
// [R5] enable high starts the start-up period with processing active
// [R6] start-up length follows the selected rate band
// [R7] after start-up the receiver enters receiving mode by itself
// [R8] in receiving mode the data output follows the demodulator signal
// [R9] output passing starts at the first falling demodulator edge
// [R10] receiving lasts until enable falls, then back to sleep
// [R11] demodulator sampled on extended tick; output changes only on it
// [R12] output edge spacing is a whole number of extended ticks
// [R13] output edges never closer than the minimum gap; spikes dropped
// [R14] band pins high,low: 00 band 0, 01 band 1, 10 band 2
// [R15] start-up is 896.5, 512.5, 512.5, 320.5 base ticks, half-tick counted
// [R16] minimum output edge gap is ten extended ticks
module rx_ctrl_core #(
  parameter int GAP_EXT_P = rx_ctrl_pkg::GAP_EXT
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_ce,
  input  wire logic        i_enable,
  input  wire logic        i_mode,
  input  wire logic        i_band_sel_lo,
  input  wire logic        i_band_sel_hi,
  input  wire logic        i_demod,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_data,
  output logic             o_rx_active,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr
);
  import rx_ctrl_pkg::*;

  // the gap counter is 8 bits wide; larger gaps cannot be counted
  if (GAP_EXT_P < 1 || GAP_EXT_P > 255) begin : g_gap_check
    $error("GAP_EXT_P must lie in 1..255");
  end

  // ***************************************************************
  // state
  // ***************************************************************
  rx_state_t   state_reg;
  rx_state_t   state_next;
  logic [1:0]  rate_band_reg;
  logic [10:0] su_cnt_reg;
  logic [7:0]  gap_cnt_reg;
  logic        samp_reg;
  logic        data_reg;
  logic        active_reg;
  logic [31:0] ctrl_reg;
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        base_tick;
  logic        half_tick;
  logic        ext_tick;

  rx_tick_gen u_ticks (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_ce        (i_ce),
    .i_mode      (i_mode),
    .i_rate_band (rate_band_reg),
    .o_base_tick (base_tick),
    .o_half_tick (half_tick),
    .o_ext_tick  (ext_tick)
  );

  // ***************************************************************
  // band decode and timing selection
  // ***************************************************************
  // pins cannot reach band 3; software reaches it through the control bit
  wire        band3_sel  = ctrl_reg[CTRL_BAND3_BIT];
  wire  [1:0] band_pins  = {i_band_sel_hi, i_band_sel_hi ? 1'b0 : i_band_sel_lo}; // [R14]
  wire  [1:0] band_next  = band3_sel ? 2'h3 : band_pins;
  wire [10:0] su_limit   = (rate_band_reg == 2'h0) ? 11'(STARTUP_HALF0 - 1) : // [R6]
                           (rate_band_reg == 2'h1) ? 11'(STARTUP_HALF1 - 1) :
                           (rate_band_reg == 2'h2) ? 11'(STARTUP_HALF2 - 1) : 11'(STARTUP_HALF3 - 1);
  wire        su_done    = half_tick && (su_cnt_reg >= su_limit); // [R15]
  // saturating gap count: a quiet line never wraps into an early edge
  wire  [7:0] gap_full_v = 8'(GAP_EXT_P - 1);
  wire        gap_full   = (gap_cnt_reg >= gap_full_v); // [R16]
  wire        fall_seen  = ext_tick && samp_reg && !i_demod; // [R9]
  wire        data_move  = ext_tick && gap_full && (i_demod != data_reg); // [R11] [R13]

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_SLEEP:     state_next = i_enable ? ST_STARTUP : ST_SLEEP; // [R5]
      ST_STARTUP:   state_next = su_done ? ST_WAIT_FALL : ST_STARTUP; // [R7]
      ST_WAIT_FALL: state_next = fall_seen ? ST_RECEIVE : ST_WAIT_FALL;
      ST_RECEIVE:   state_next = ST_RECEIVE;
      default:      state_next = ST_SLEEP;
    endcase
    if (!i_enable) begin
      state_next = ST_SLEEP; // [R3] [R10]
    end
  end

  // ***************************************************************
  // sequencer and output re-timing
  // ***************************************************************
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_reg     <= ST_SLEEP;
      rate_band_reg <= 2'h0;
      su_cnt_reg    <= 11'h000;
      gap_cnt_reg   <= 8'h00;
      samp_reg      <= 1'b0;
      data_reg      <= 1'b0;
      active_reg    <= 1'b0;
    end else if (i_ce) begin
      state_reg     <= state_next;
      rate_band_reg <= band_next;
      active_reg    <= (state_next != ST_SLEEP); // [R4] [R5]
      if (state_reg == ST_STARTUP && half_tick) begin
        su_cnt_reg <= su_cnt_reg + 11'h001;
      end else if (state_reg != ST_STARTUP) begin
        su_cnt_reg <= 11'h000;
      end
      if (state_next == ST_SLEEP || state_next == ST_STARTUP) begin
        samp_reg    <= 1'b0; // [R4]
        data_reg    <= 1'b0;
        gap_cnt_reg <= 8'h00;
      end else if (ext_tick) begin
        samp_reg <= i_demod; // [R11]
        // entry cycles keep data low and the gap fresh, even for a one-tick gap
        if (state_reg != ST_RECEIVE) begin
          data_reg    <= 1'b0;
          gap_cnt_reg <= 8'h00;
        end else if (data_move) begin
          data_reg    <= i_demod; // [R8] [R12]
          gap_cnt_reg <= 8'h00;
        end else if (!gap_full) begin
          gap_cnt_reg <= gap_cnt_reg + 8'h01;
        end
      end
    end
  end

  // ***************************************************************
  // apb slave
  // ***************************************************************
  wire        hit_ctrl   = (i_paddr == ADDR_CTRL);
  wire        hit_status = (i_paddr == ADDR_STATUS);
  wire        apb_access = i_psel && i_penable && !pready_reg;
  wire        apb_write  = i_psel && i_penable && pready_reg && i_pwrite;
  wire [31:0] status_w   = {23'h000000, data_reg, 2'h0, rate_band_reg, 2'h0, state_reg};
  // unmapped reads give zero; pslverr tells the host why
  wire [31:0] rd_data    = hit_ctrl ? ctrl_reg : (hit_status ? status_w : 32'h00000000);

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_reg    <= CTRL_RST;
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else if (i_ce) begin
      pready_reg  <= apb_access;
      pslverr_reg <= apb_access && !(hit_ctrl || hit_status);
      prdata_reg  <= (apb_access && !i_pwrite) ? rd_data : 32'h00000000;
      if (apb_write && hit_ctrl) begin
        ctrl_reg <= {31'h00000000, i_pwdata[CTRL_BAND3_BIT]};
      end
    end
  end

  assign o_data      = data_reg;
  assign o_rx_active = active_reg;
  assign o_pready    = pready_reg;
  assign o_prdata    = prdata_reg;
  assign o_pslverr   = pslverr_reg;

  // ***************************************************************
  // checks
  // ***************************************************************
  a_sleep_quiet: assert property (@(posedge i_clk) disable iff (i_reset) // [R4]
    (state_reg == ST_SLEEP) |-> (!data_reg && !active_reg)) else $error("activity while asleep");
  a_enable_low_sleep: assert property (@(posedge i_clk) disable iff (i_reset) // [R3]
    (i_ce && !i_enable) |=> (state_reg == ST_SLEEP)) else $error("enable low did not force sleep");
  a_wake_startup: assert property (@(posedge i_clk) disable iff (i_reset) // [R5]
    (i_ce && i_enable && state_reg == ST_SLEEP) |=> (state_reg == ST_STARTUP && active_reg))
    else $error("enable high did not start up");
  a_startup_length: assert property (@(posedge i_clk) disable iff (i_reset) // [R15]
    (state_reg == ST_STARTUP && $past(state_reg) == ST_STARTUP && state_next == ST_WAIT_FALL && i_ce)
    |-> (su_cnt_reg == su_limit)) else $error("start-up length wrong");
  a_band_decode: assert property (@(posedge i_clk) disable iff (i_reset) // [R14]
    (i_ce && !band3_sel && !i_band_sel_hi) |=> (rate_band_reg == {1'b0, $past(i_band_sel_lo)}))
    else $error("band decode wrong");
  a_wait_low: assert property (@(posedge i_clk) disable iff (i_reset) // [R9]
    (state_reg == ST_WAIT_FALL) |-> !data_reg) else $error("data passed before falling edge");
  a_edge_on_tick: assert property (@(posedge i_clk) disable iff (i_reset) // [R11]
    (state_reg == ST_RECEIVE && $past(state_reg) == ST_RECEIVE && $changed(data_reg))
    |-> $past(ext_tick)) else $error("output edge off the extended tick");
  a_min_gap: assert property (@(posedge i_clk) disable iff (i_reset) // [R13]
    (state_reg == ST_RECEIVE && $past(state_reg) == ST_RECEIVE && $changed(data_reg))
    |-> ($past(gap_cnt_reg) == gap_full_v && gap_cnt_reg == 8'h00)) else $error("output edges too close");
  a_follow_demod: assert property (@(posedge i_clk) disable iff (i_reset) // [R8]
    (state_reg == ST_RECEIVE && state_next == ST_RECEIVE && data_move && i_ce)
    |=> (data_reg == $past(i_demod))) else $error("output did not follow demodulator");

  // ***************************************************************
  // sequencer checks
  // ***************************************************************
  // every way out of sleep passes through the wake pin
  // and every way into receiving passes through start-up and a falling edge
  a_wake_needs_enable: assert property (@(posedge i_clk) disable iff (i_reset) // [R3]
    (state_reg != ST_SLEEP && $past(state_reg) == ST_SLEEP)
    |-> $past(i_enable))
    else $error("left sleep without the wake pin");
  a_wait_from_startup: assert property (@(posedge i_clk) disable iff (i_reset) // [R7]
    (state_reg == ST_WAIT_FALL && $past(state_reg) != ST_WAIT_FALL)
    |-> ($past(state_reg) == ST_STARTUP && $past(su_done)))
    else $error("waiting for an edge without a finished start-up");
  a_wait_holds: assert property (@(posedge i_clk) disable iff (i_reset) // [R9]
    (i_ce && i_enable && state_reg == ST_WAIT_FALL && !fall_seen)
    |=> (state_reg == ST_WAIT_FALL))
    else $error("left edge wait without a falling edge");
  a_receive_from_fall: assert property (@(posedge i_clk) disable iff (i_reset) // [R9]
    (state_reg == ST_RECEIVE && $past(state_reg) == ST_WAIT_FALL)
    |-> ($past(fall_seen) && !data_reg))
    else $error("receiving began without a falling edge");
  a_receive_holds: assert property (@(posedge i_clk) disable iff (i_reset) // [R10]
    (i_ce && i_enable && state_reg == ST_RECEIVE)
    |=> (state_reg == ST_RECEIVE))
    else $error("receiving ended with the wake pin high");
  a_active_match: assert property (@(posedge i_clk) disable iff (i_reset) // [R5]
    (state_reg != ST_SLEEP)
    |-> active_reg)
    else $error("active flag low while awake");
  a_sleep_ignores: assert property (@(posedge i_clk) disable iff (i_reset) // [R4]
    (i_ce && state_reg == ST_SLEEP)
    |=> (!samp_reg && gap_cnt_reg == 8'h00))
    else $error("demodulator sampled while asleep");

  // ***************************************************************
  // start-up counter checks
  // ***************************************************************
  // the counter moves on half ticks only, so its end point is exact
  a_su_count_clear: assert property (@(posedge i_clk) disable iff (i_reset) // [R15]
    (i_ce && state_reg != ST_STARTUP)
    |=> (su_cnt_reg == 11'h000))
    else $error("start-up count left over");
  a_su_half_only: assert property (@(posedge i_clk) disable iff (i_reset) // [R15]
    (i_ce && !half_tick && state_reg == ST_STARTUP)
    |=> $stable(su_cnt_reg))
    else $error("start-up count moved off a half tick");
  a_half_on_base: assert property (@(posedge i_clk) disable iff (i_reset) // [R15]
    base_tick
    |-> half_tick)
    else $error("base tick without half tick");
  a_startup_quiet: assert property (@(posedge i_clk) disable iff (i_reset) // [R9]
    (state_reg == ST_STARTUP)
    |-> (!data_reg && !samp_reg && gap_cnt_reg == 8'h00))
    else $error("data path busy during start-up");

  // ***************************************************************
  // output re-timing checks
  // ***************************************************************
  // a frozen clock enable must not shift the edge spacing off the tick grid
  a_gap_bounded: assert property (@(posedge i_clk) disable iff (i_reset) // [R16]
    1'b1
    |-> (gap_cnt_reg <= gap_full_v))
    else $error("gap counter beyond its limit");
  a_ext_sampled: assert property (@(posedge i_clk) disable iff (i_reset) // [R11]
    (i_ce && ext_tick && state_reg == ST_RECEIVE && state_next == ST_RECEIVE)
    |=> (samp_reg == $past(i_demod)))
    else $error("demodulator not sampled on the extended tick");
  a_still_off_tick: assert property (@(posedge i_clk) disable iff (i_reset) // [R12]
    (state_reg == ST_RECEIVE && i_enable && !(i_ce && ext_tick))
    |=> $stable(data_reg))
    else $error("output moved between extended ticks");
  a_ce_freeze: assert property (@(posedge i_clk) disable iff (i_reset) // [R11]
    !i_ce
    |=> ($stable(state_reg) && $stable(data_reg) && $stable(su_cnt_reg) && $stable(gap_cnt_reg)))
    else $error("state moved with clock enable low");

  // ***************************************************************
  // band select checks
  // ***************************************************************
  // band 3 exists only through the control bit
  a_band_three: assert property (@(posedge i_clk) disable iff (i_reset) // [R2]
    (i_ce && band3_sel)
    |=> (rate_band_reg == 2'h3))
    else $error("forced band 3 not applied");
  a_band_hi_pins: assert property (@(posedge i_clk) disable iff (i_reset) // [R14]
    (i_ce && !band3_sel && i_band_sel_hi)
    |=> (rate_band_reg == 2'h2))
    else $error("high band pin did not give band 2");
endmodule

/* bench/host_mcu_model.sv */
// Purpose: host controller model: drives wake, mode and band pins, times DATA edges
// Assumes: DATA is sampled on every rising edge of i_clk
// Notes:   edge gaps are judged only while the wake pin is high
`timescale 1ns/100ps
module host_mcu_model (
  input  wire logic i_clk,
  input  wire logic i_data,
  input  int        i_ext_clocks,
  input  int        i_gap_ext,
  output logic      o_enable,
  output logic      o_mode,
  output logic      o_band_sel_lo,
  output logic      o_band_sel_hi,
  output int        o_bad_gaps,
  output int        o_edges
);
  logic last_data;
  logic armed;
  int   since_edge;

  initial begin
    {o_enable, o_mode, o_band_sel_hi, o_band_sel_lo} = 4'h0;
    o_bad_gaps = 0;
    o_edges = 0;
    armed = 1'b0;
  end

  // pins change just after an edge and stand until the next command
  task automatic drive_pins(input logic en, input logic md, input logic hi, input logic lo);
    @(posedge i_clk);
    o_enable      <= en;
    o_mode        <= md;
    o_band_sel_hi <= hi;
    o_band_sel_lo <= lo;
  endtask

  // *****************************************************************
  // edge spacing watch
  // *****************************************************************
  always @(posedge i_clk) begin
    if (!o_enable) begin
      armed      <= 1'b0;
      since_edge <= 0;
      last_data  <= i_data;
    end else if (i_data !== last_data) begin
      if (armed && ((since_edge % i_ext_clocks) != 0 || since_edge < i_gap_ext * i_ext_clocks)) begin
        o_bad_gaps <= o_bad_gaps + 1;
      end
      armed      <= 1'b1;
      o_edges    <= o_edges + 1;
      since_edge <= 1;
      last_data  <= i_data;
    end else begin
      since_edge <= since_edge + 1;
    end
  end
endmodule

/* bench/rx_clock_enable_debounce_tb.sv */
// Purpose: self-checking bench of the receiver control core
// Assumes: band 3 forced through CTRL keeps start-up short
// Notes:   host pins come from the host model, demodulator and APB from here
`timescale 1ns/100ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin mismatches++; $display("mismatch at %0t: compare failed", $time); end end
module rx_clock_enable_debounce_tb;
  import rx_ctrl_pkg::*;
  logic        i_clk = 0, i_reset = 1, i_demod = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, err;
  logic        ce = 1'b1;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h00000000, rd;
  wire         en, md, bs_lo, bs_hi, o_data, o_rx_active, o_pready, o_pslverr;
  wire  [31:0] o_prdata;
  int          mismatches = 0, tests_run = 0, cyc = 0, bad_gaps, edges;

  always #4 i_clk = ~i_clk;

  rx_ctrl_core dut (.i_clk(i_clk), .i_reset(i_reset), .i_ce(ce), .i_enable(en), .i_mode(md),
    .i_band_sel_lo(bs_lo), .i_band_sel_hi(bs_hi), .i_demod(i_demod), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_data(o_data), .o_rx_active(o_rx_active), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr));
  host_mcu_model model (.i_clk(i_clk), .i_data(o_data), .i_ext_clocks(DIV_MODE_LO * EXT_PER3),
    .i_gap_ext(GAP_EXT), .o_enable(en), .o_mode(md), .o_band_sel_lo(bs_lo), .o_band_sel_hi(bs_hi),
    .o_bad_gaps(bad_gaps), .o_edges(edges));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard: the whole run needs well under this many cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge i_clk);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {1'b1, 1'b0, wr, a, wd};
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    {i_psel, i_penable} <= 2'b00;
  endtask

  task automatic t_reset();
    `CHK(o_data, 1'b0)
    `CHK(o_rx_active, 1'b0)
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd, 32'h00000000)
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK(rd, CTRL_RST)
    apb(1'b0, 12'h010, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h00000000)
  endtask

  task automatic t_bands();
    logic [1:0] sel;
    for (int i = 0; i < 4; i++) begin
      sel = i[1:0];
      model.drive_pins(1'b0, 1'b0, sel[1], sel[0]);
      apb(1'b0, ADDR_STATUS, 32'h0);
      `CHK(rd[STAT_BAND_LSB+:2], (sel == 2'h3) ? 2'h2 : sel)
    end
    model.drive_pins(1'b0, 1'b0, 1'b0, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h00000001);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd[STAT_BAND_LSB+:2], 2'h3)
  endtask

  // start-up length in clocks is half ticks times half the divider
  task automatic t_startup(input logic mode, input int div, input logic lo, input int half);
    int t0, len, k;
    model.drive_pins(1'b1, mode, 1'b0, lo);
    t0 = cyc;
    repeat (2) @(posedge i_clk);
    `CHK(o_rx_active, 1'b1)
    k = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      k++;
    end while (rd[1:0] === 2'h1 && k < 2000);
    len = cyc - t0;
    `CHK(len >= half * div / 2 - 4 && len <= half * div / 2 + div + 16, 1'b1)
    `CHK(rd[1:0], 2'h2)
  endtask

  task automatic t_receive();
    int k;
    i_demod <= 1'b1;
    repeat (30) @(posedge i_clk);
    i_demod <= 1'b0;
    repeat (30) @(posedge i_clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd[1:0], 2'h3)
    `CHK(rd[STAT_DATA_BIT], 1'b0)
    `CHK(o_data, 1'b0)
    i_demod <= 1'b1;
    repeat (40) @(posedge i_clk);
    `CHK(o_data, 1'b0)
    k = 0;
    while (o_data !== 1'b1 && k < 120) begin
      @(posedge i_clk);
      k++;
    end
    `CHK(o_data, 1'b1)
    i_demod <= 1'b0;
    repeat (30) @(posedge i_clk);
    i_demod <= 1'b1;
    repeat (200) @(posedge i_clk);
    `CHK(o_data, 1'b1)
    i_demod <= 1'b0;
    repeat (150) @(posedge i_clk);
    `CHK(o_data, 1'b0)
    i_demod <= 1'b1;
    repeat (150) @(posedge i_clk);
    `CHK(o_data, 1'b1)
    ce <= 1'b0;
    i_demod <= 1'b0;
    repeat (200) @(posedge i_clk);
    `CHK(o_data, 1'b1)
    ce <= 1'b1;
    i_demod <= 1'b1;
    `CHK(bad_gaps, 0)
    `CHK(edges >= 3, 1'b1)
    model.drive_pins(1'b0, 1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge i_clk);
    `CHK(o_data, 1'b0)
    `CHK(o_rx_active, 1'b0)
    i_demod <= 1'b0;
    repeat (50) @(posedge i_clk);
    i_demod <= 1'b1;
    repeat (50) @(posedge i_clk);
    `CHK(o_data, 1'b0)
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd[1:0], 2'h0)
  endtask

  initial begin
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    t_reset();
    t_bands();
    apb(1'b1, ADDR_CTRL, 32'h00000000);
    t_startup(1'b0, DIV_MODE_LO, 1'b1, STARTUP_HALF1);
    model.drive_pins(1'b0, 1'b0, 1'b0, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h00000001);
    t_startup(1'b1, DIV_MODE_HI, 1'b0, STARTUP_HALF3);
    model.drive_pins(1'b0, 1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge i_clk);
    t_startup(1'b0, DIV_MODE_LO, 1'b0, STARTUP_HALF3);
    t_receive();
    print_verdict();
  end
endmodule
